// [cmp_vref_pkg.sv]
// Purpose: Shared constants and carriers for comparator and reference control
// Assumes: 8-bit register address and data on a plain strobe port
// Notes:   Mode codes and bit positions are fixed by the register layout
package cmp_vref_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_INT_CTRL = 8'h0b;
   localparam logic [7:0] ADDR_FLAG     = 8'h0c;
   localparam logic [7:0] ADDR_CMP_CTRL = 8'h1f;
   localparam logic [7:0] ADDR_DIR_A    = 8'h85;
   localparam logic [7:0] ADDR_ENABLE   = 8'h8c;
   localparam logic [7:0] ADDR_REF_CTRL = 8'h9f;

   // Field positions
   localparam int BIT_GIE    = 7;
   localparam int BIT_PERIPHERAL_IRQ_EN   = 6;
   localparam int BIT_CHG    = 6;
   localparam int BIT_CHG_IE = 6;
   localparam int BIT_COMP2_RESULT  = 7;
   localparam int BIT_COMP1_RESULT  = 6;
   localparam int BIT_SWITCH = 3;
   localparam int BIT_REF_EN = 7;
   localparam int BIT_REF_OE = 6;
   localparam int BIT_RANGE  = 5;
   localparam int BIT_DIR_A2 = 2;
   localparam int LEVEL_MSB  = 3;

   // Reset values and writable masks
   localparam logic [7:0] INT_CTRL_RST = 8'h00;
   localparam logic [7:0] CMP_CTRL_RST = 8'h00;
   localparam logic [7:0] REF_CTRL_RST = 8'h00;
   localparam logic [4:0] DIR_A_RST    = 5'h1f;
   localparam logic [7:0] CMP_WR_MASK  = 8'h0f;
   localparam logic [7:0] REF_WR_MASK  = 8'hef;

   // Comparator mode codes
   localparam logic [2:0] MODE_RESET   = 3'h0;
   localparam logic [2:0] MODE_SWITCH1 = 3'h1;
   localparam logic [2:0] MODE_LADDER  = 3'h2;
   localparam logic [2:0] MODE_PIN_OUT = 3'h6;
   localparam logic [2:0] MODE_OFF     = 3'h7;

   // Ladder tap as a fraction of supply in 96ths
   localparam logic [6:0] LADDER_DEN     = 7'h60;
   localparam logic [6:0] LADDER_QUARTER = 7'h18;
   localparam logic [6:0] STEP_HIGH_RNG  = 7'h04;
   localparam logic [6:0] STEP_LOW_RNG   = 7'h03;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   typedef struct packed {
      logic comp_power;
      logic vin_plus_ladder;
      logic c1_inv_a3;
      logic c2_inv_a2;
      logic pins_out_cmp;
   } route_t;

   typedef struct packed {
      logic       power;
      logic [6:0] num;
   } ladder_t;
endpackage

// [result_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous comparator results
// Assumes: Inputs come straight from the analog comparators
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ns
module result_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   if (WIDTH < 1) begin : g_chk
      $error("result_sync needs WIDTH of at least one");
   end

   // First stage feeds the second and nothing else
   always_comb begin
      next_state.stage1 = d;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign q = state.stage2;
endmodule

// [ref_ladder.sv]
// Purpose: Tap selection and power control for the reference ladder
// Assumes: Analog ladder takes a tap numerator over a fixed denominator
// Notes:   Output is one cycle behind the control register
`timescale 1ns/1ns
module ref_ladder
   import cmp_vref_pkg::*;
#(
   parameter int LEVEL_W = 4
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               enable,
   input  wire logic               range_sel,
   input  wire logic [LEVEL_W-1:0] level,
   output cmp_vref_pkg::ladder_t   ladder
);
   import cmp_vref_pkg::*;

   ladder_t state;
   ladder_t next_state;

   // Tap table is sized for sixteen levels per range
   if (LEVEL_W != 4) begin : g_chk
      $error("ref_ladder supports only a 4-bit level");
   end

   // High range steps by 1/24, low range starts at 1/4 and steps by 1/32
   always_comb begin
      next_state.power = enable;
      if (range_sel) begin
         next_state.num = 7'(STEP_HIGH_RNG * level);
      end else begin
         next_state.num = 7'(LADDER_QUARTER + STEP_LOW_RNG * level);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign ladder = state;
endmodule

// [cmp_vref_ctrl.sv]
// Purpose: Register file and digital control of two comparators and ladder
// Assumes: Comparator results arrive asynchronous to clk
// Notes:   Pin outputs in pin-out mode bypass the synchroniser by design
// How it works
// - Mode 010 routes ladder voltage to both non-inverting inputs.
// - Comparator results read at control bits 7:6, writes ignored there.
// - Mode 110 puts raw comparator results on pins A3 and A4.
// - Any comparator result change sets the change flag.
// - Software clears flag by writing zero; writing one sets it.
// - Interrupt needs flag, its enable, peripheral and global enables.
// - Persisting mismatch keeps setting flag; control access ends it.
// - Change during a control read may be missed; here never missed.
// - Comparators keep running in sleep; enabled change wakes device.
// - Mode 111 powers both comparators down.
// - Wake from sleep leaves comparator control unchanged.
// - Reset clears comparator control and holds comparators off.
// - Ladder gives level/24 or 1/4 plus level/32 of supply.
// - Ladder is powered down while the reference enable is clear.
// - Reset clears reference enable, pin enable, range and level.
// - Wake from sleep leaves reference control unchanged.
// - Reference drives pin A2 only with direction bit 2 and pin enable.
// - Reference controls act independently of comparator mode.
// - Input switch picks inverting pins in modes 001 and 010.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module cmp_vref_ctrl (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire cmp_vref_pkg::bus_req_t bus,
   output logic [7:0]                 rdata,
   input  wire logic                  sleep,
   input  wire logic [1:0]            comp_raw,
   output cmp_vref_pkg::route_t       route,
   output cmp_vref_pkg::ladder_t      ladder,
   output logic                       pin_a3_out,
   output logic                       pin_a4_out,
   output logic                       pin_a2_ref_en,
   output logic [4:0]                 port_a_dir,
   output logic                       comparator_irq,
   output logic                       wake_req
);
   import cmp_vref_pkg::*;

   typedef struct packed {
      logic [7:0] interrupt_control_reg;
      logic       comparator_change_flag;
      logic       comparator_change_irq_en;
      logic [2:0] comparator_mode_sel;
      logic       input_switch_sel;
      logic [7:0] reference_control_reg;
      logic [4:0] port_a_direction;
      logic [1:0] latched;
      logic [7:0] rdata;
      route_t     route;
   } state_t;

   state_t     state;
   state_t     next_state;
   logic [1:0] synced;
   logic [1:0] results;
   logic       mismatch;
   logic       cmp_access;
   logic       global_irq_en;
   logic       peripheral_irq_en;

   // Decode a write or read strobe for one address
   function automatic logic hit(input bus_req_t b, input logic [7:0] a);
      hit = (b.wr || b.rd) && (b.addr == a);
   endfunction

   function automatic logic wr_hit(input bus_req_t b, input logic [7:0] a);
      wr_hit = b.wr && (b.addr == a);
   endfunction

   // Metastability guard before any compare logic sees the results
   result_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (comp_raw),
      .q   (synced)
   );

   ref_ladder #(
      .LEVEL_W (4)
   ) u_ladder (
      .clk       (clk),
      .rst       (rst),
      .enable    (state.reference_control_reg[BIT_REF_EN]),
      .range_sel (state.reference_control_reg[BIT_RANGE]),
      .level     (state.reference_control_reg[LEVEL_MSB:0]),
      .ladder    (ladder)
   );

   // A powered-down comparator reports low so it cannot raise changes
   assign results = state.route.comp_power ? synced : 2'b00;
   assign cmp_access = hit(bus, ADDR_CMP_CTRL);
   assign mismatch = (results != state.latched);
   assign global_irq_en = state.interrupt_control_reg[BIT_GIE];
   assign peripheral_irq_en = state.interrupt_control_reg[BIT_PERIPHERAL_IRQ_EN];

   // Register updates, mismatch latch and read data
   always_comb begin
      next_state = state;
      // Any control access resamples the reference copy
      if (cmp_access) begin
         next_state.latched = results;
      end
      if (wr_hit(bus, ADDR_INT_CTRL)) begin
         next_state.interrupt_control_reg = bus.wdata;
      end
      if (wr_hit(bus, ADDR_CMP_CTRL)) begin
         // Result bits and the unused pair are not writable
         next_state.comparator_mode_sel = bus.wdata[2:0];
         next_state.input_switch_sel = bus.wdata[BIT_SWITCH];
      end
      if (wr_hit(bus, ADDR_REF_CTRL)) begin
         next_state.reference_control_reg = bus.wdata & REF_WR_MASK;
      end
      if (wr_hit(bus, ADDR_DIR_A)) begin
         next_state.port_a_direction = bus.wdata[4:0];
      end
      if (wr_hit(bus, ADDR_ENABLE)) begin
         next_state.comparator_change_irq_en = bus.wdata[BIT_CHG_IE];
      end
      // Software write of either value, then hardware set wins
      if (wr_hit(bus, ADDR_FLAG)) begin
         next_state.comparator_change_flag = bus.wdata[BIT_CHG];
      end
      // Checked every cycle, also during a control read
      if (mismatch) begin
         next_state.comparator_change_flag = 1'b1;
      end
      // Routing follows the mode that will be held next cycle
      next_state.route.comp_power =
         (next_state.comparator_mode_sel != MODE_OFF);
      next_state.route.vin_plus_ladder =
         (next_state.comparator_mode_sel == MODE_LADDER);
      next_state.route.c1_inv_a3 = next_state.input_switch_sel &&
         ((next_state.comparator_mode_sel == MODE_SWITCH1) ||
          (next_state.comparator_mode_sel == MODE_LADDER));
      next_state.route.c2_inv_a2 = next_state.input_switch_sel &&
         (next_state.comparator_mode_sel == MODE_LADDER);
      next_state.route.pins_out_cmp =
         (next_state.comparator_mode_sel == MODE_PIN_OUT);
      // Read data for the cycle after the strobe; unmapped reads zero
      next_state.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_INT_CTRL: next_state.rdata = state.interrupt_control_reg;
            ADDR_FLAG: next_state.rdata[BIT_CHG] =
               state.comparator_change_flag;
            ADDR_CMP_CTRL: begin
               next_state.rdata[BIT_COMP2_RESULT] = results[1];
               next_state.rdata[BIT_COMP1_RESULT] = results[0];
               next_state.rdata[BIT_SWITCH] = state.input_switch_sel;
               next_state.rdata[2:0] = state.comparator_mode_sel;
            end
            ADDR_DIR_A: next_state.rdata[4:0] = state.port_a_direction;
            ADDR_ENABLE: next_state.rdata[BIT_CHG_IE] =
               state.comparator_change_irq_en;
            ADDR_REF_CTRL: next_state.rdata = state.reference_control_reg;
            default: next_state.rdata = 8'h00;
         endcase
      end
   end

   // Sleep only gates the wake request, so registers hold across sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         state.interrupt_control_reg <= INT_CTRL_RST;
         state.comparator_change_flag <= 1'b0;
         state.comparator_change_irq_en <= 1'b0;
         state.comparator_mode_sel <= CMP_CTRL_RST[2:0];
         state.input_switch_sel <= CMP_CTRL_RST[BIT_SWITCH];
         state.reference_control_reg <= REF_CTRL_RST;
         state.port_a_direction <= DIR_A_RST;
         state.latched <= 2'b00;
         state.rdata <= 8'h00;
         state.route <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign route = state.route;
   assign port_a_dir = state.port_a_direction;
   // Raw, unsynchronised path so pins track the comparators directly
   assign pin_a3_out = state.route.pins_out_cmp & comp_raw[0];
   assign pin_a4_out = state.route.pins_out_cmp & comp_raw[1];
   assign pin_a2_ref_en = state.port_a_direction[BIT_DIR_A2] &&
      state.reference_control_reg[BIT_REF_OE];
   assign comparator_irq = state.comparator_change_flag &&
      state.comparator_change_irq_en && peripheral_irq_en &&
      global_irq_en;
   // Wake needs only the local enable, the core gates the vector
   assign wake_req = sleep && state.comparator_change_flag &&
      state.comparator_change_irq_en;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_ladder_route;
      wr_hit(bus, ADDR_CMP_CTRL) && (bus.wdata[2:0] == MODE_LADDER)
         |=> route.vin_plus_ladder && !route.pins_out_cmp;
   endproperty
   a_ladder_route: assert property (p_ladder_route)
      else $error("ladder not routed in mode 010");

   property p_result_read;
      cmp_access && bus.rd |=> (rdata[7:6] == $past(results)) &&
         (rdata[5:4] == 2'b00);
   endproperty
   a_result_read: assert property (p_result_read)
      else $error("comparator result read wrong");

   property p_pin_out;
      wr_hit(bus, ADDR_CMP_CTRL) && (bus.wdata[2:0] == MODE_PIN_OUT)
         |=> (pin_a3_out == comp_raw[0]) && (pin_a4_out == comp_raw[1]);
   endproperty
   a_pin_out: assert property (p_pin_out)
      else $error("pins not carrying comparator results");

   property p_change_sets;
      mismatch |=> state.comparator_change_flag;
   endproperty
   a_change_sets: assert property (p_change_sets)
      else $error("change flag not set on result change");

   property p_flag_write;
      wr_hit(bus, ADDR_FLAG) && !mismatch
         |=> state.comparator_change_flag == $past(bus.wdata[BIT_CHG]);
   endproperty
   a_flag_write: assert property (p_flag_write)
      else $error("change flag write not honoured");

   property p_irq_gate;
      !global_irq_en || !state.comparator_change_irq_en |-> !comparator_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt raised while disabled");

   property p_access_ends;
      cmp_access ##1 ($stable(results) && !bus.wr && !bus.rd) |-> !mismatch;
   endproperty
   a_access_ends: assert property (p_access_ends)
      else $error("control access did not end mismatch");

   property p_off_mode;
      wr_hit(bus, ADDR_CMP_CTRL) && (bus.wdata[2:0] == MODE_OFF)
         |=> !route.comp_power ##1 (results == 2'b00);
   endproperty
   a_off_mode: assert property (p_off_mode)
      else $error("comparators not off in mode 111");

   property p_reset_state;
      disable iff (1'b0)
      $past(rst) |-> (state.comparator_mode_sel == MODE_RESET) &&
         !route.comp_power && (state.reference_control_reg == 8'h00);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset state not applied");

   property p_ladder_tap;
      wr_hit(bus, ADDR_REF_CTRL) && bus.wdata[BIT_RANGE]
         |=> ##1 ladder.num == 7'(STEP_HIGH_RNG * $past(bus.wdata[3:0], 2));
   endproperty
   a_ladder_tap: assert property (p_ladder_tap)
      else $error("high range tap wrong");

   property p_ref_pin;
      !state.port_a_direction[BIT_DIR_A2] |-> !pin_a2_ref_en;
   endproperty
   a_ref_pin: assert property (p_ref_pin)
      else $error("reference driven on pin A2 while output");

   property p_sleep_active;
      sleep && (state.comparator_mode_sel != MODE_OFF) |-> route.comp_power;
   endproperty
   a_sleep_active: assert property (p_sleep_active)
      else $error("comparators stopped during sleep");

   property p_wake;
      sleep && state.comparator_change_flag &&
         state.comparator_change_irq_en |-> wake_req;
   endproperty
   a_wake: assert property (p_wake)
      else $error("enabled change did not wake the device");

   property p_ladder_power;
      !state.reference_control_reg[BIT_REF_EN] |=> !ladder.power;
   endproperty
   a_ladder_power: assert property (p_ladder_power)
      else $error("ladder powered while reference disabled");

   property p_ref_reset;
      disable iff (1'b0)
      $past(rst) |-> (ladder == '0) && !pin_a2_ref_en;
   endproperty
   a_ref_reset: assert property (p_ref_reset)
      else $error("reference not cleared by reset");

   property p_ref_enable_any;
      wr_hit(bus, ADDR_REF_CTRL)
         |=> ##1 ladder.power == $past(bus.wdata[BIT_REF_EN], 2);
   endproperty
   a_ref_enable_any: assert property (p_ref_enable_any)
      else $error("reference enable depends on comparator mode");

   property p_switch1_route;
      wr_hit(bus, ADDR_CMP_CTRL) && (bus.wdata[2:0] == MODE_SWITCH1)
         |=> (route.c1_inv_a3 == $past(bus.wdata[BIT_SWITCH])) &&
         !route.c2_inv_a2;
   endproperty
   a_switch1_route: assert property (p_switch1_route)
      else $error("input switch wrong in mode 001");

   property p_switch2_route;
      wr_hit(bus, ADDR_CMP_CTRL) && (bus.wdata[2:0] == MODE_LADDER)
         |=> (route.c2_inv_a2 == $past(bus.wdata[BIT_SWITCH])) &&
         (route.c1_inv_a3 == $past(bus.wdata[BIT_SWITCH]));
   endproperty
   a_switch2_route: assert property (p_switch2_route)
      else $error("input switch wrong in mode 010");

   property p_latch_copy;
      cmp_access |=> state.latched == $past(results);
   endproperty
   a_latch_copy: assert property (p_latch_copy)
      else $error("result copy not taken on control access");

   property p_unused_read;
      bus.rd && (bus.addr == ADDR_REF_CTRL) |=> !rdata[4];
   endproperty
   a_unused_read: assert property (p_unused_read)
      else $error("unused reference bit reads as one");

   property p_flag_kept;
      mismatch && !global_irq_en |=> state.comparator_change_flag &&
         !comparator_irq;
   endproperty
   a_flag_kept: assert property (p_flag_kept)
      else $error("flag lost or interrupt raised while masked");
endmodule

// [comp_model.sv]
// Purpose: Behavioural analog side: ladder tap and two comparators
// Assumes: Voltages are fractions of supply in 96ths
// Notes:   Powered-off comparators give 0, not a held value
`timescale 1ns/1ns
module comp_model
   import cmp_vref_pkg::*;
(
   input  wire cmp_vref_pkg::route_t  route,
   input  wire cmp_vref_pkg::ladder_t ladder,
   input  wire logic [6:0]            ext_plus,
   input  wire logic [6:0]            ext_minus1,
   input  wire logic [6:0]            ext_minus2,
   output logic [1:0]                 comp_raw
);
   logic [6:0] vplus;

   // Unpowered ladder sits at ground so a stale tap never leaks through
   assign vplus = route.vin_plus_ladder ?
                  (ladder.power ? ladder.num : 7'h00) : ext_plus;
   // Results follow inputs at once; the design must synchronise them
   assign comp_raw[0] = route.comp_power & (vplus > ext_minus1);
   assign comp_raw[1] = route.comp_power & (vplus > ext_minus2);
endmodule

// [tb_top.sv]
// Purpose: Register-level test of comparator and reference control
// Assumes: Results stay 0 until the flag scenario moves the inputs
// Notes:   Each read samples rdata in the single cycle it stands
`timescale 1ns/1ns
module tb_top;
   import cmp_vref_pkg::*;
   logic       clk;
   logic       rst;
   logic       sleep;
   bus_req_t   bus;
   logic [7:0] rdata;
   route_t     route;
   route_t     exp_route;
   ladder_t    ladder;
   logic       pin_a3_out;
   logic       pin_a4_out;
   logic       pin_a2_ref_en;
   logic [4:0] port_a_dir;
   logic       comparator_irq;
   logic       wake_req;
   logic [1:0] comp_raw;
   logic [6:0] ext_plus;
   logic [6:0] ext_minus1;
   logic [6:0] ext_minus2;
   logic [6:0] lv;
   int         err_total;
   int         check_count;
   int         cycles;

   cmp_vref_ctrl u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .sleep(sleep), .comp_raw(comp_raw), .route(route), .ladder(ladder),
      .pin_a3_out(pin_a3_out), .pin_a4_out(pin_a4_out),
      .pin_a2_ref_en(pin_a2_ref_en), .port_a_dir(port_a_dir),
      .comparator_irq(comparator_irq), .wake_req(wake_req));
   comp_model u_model (.route(route), .ladder(ladder), .ext_plus(ext_plus),
      .ext_minus1(ext_minus1), .ext_minus2(ext_minus2),
      .comp_raw(comp_raw));

   // Clock and hang guard
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         summarize();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write strobe; leaves the bus idle for one edge after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
      #1;
   endtask

   // Read data stands only in the cycle after the strobe edge
   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1;
      check($sformatf("reg_%h", a), rdata, exp);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      clk = 0; rst = 1; sleep = 0; bus = '0; ext_plus = 7'h00;
      ext_minus1 = 7'h7f; ext_minus2 = 7'h7f;
      err_total = 0; check_count = 0; cycles = 0;
      tick(11);
      check("power_in_reset", {7'h00, route.comp_power}, 8'h00);
      @(posedge clk);
      rst <= 1'b0;
      // Reset values, unmapped place
      rd_check(ADDR_INT_CTRL, 8'h00);
      rd_check(ADDR_FLAG, 8'h00);
      rd_check(ADDR_CMP_CTRL, 8'h00);
      rd_check(ADDR_DIR_A, 8'h1f);
      rd_check(ADDR_ENABLE, 8'h00);
      rd_check(ADDR_REF_CTRL, 8'h00);
      wr(8'h40, 8'hff);
      rd_check(8'h40, 8'h00);
      // Writable masks; result bits stay 0 with comparators off
      wr(ADDR_CMP_CTRL, 8'hff);
      rd_check(ADDR_CMP_CTRL, 8'h0f);
      wr(ADDR_REF_CTRL, 8'hff);
      rd_check(ADDR_REF_CTRL, 8'hef);
      wr(ADDR_DIR_A, 8'hff);
      rd_check(ADDR_DIR_A, 8'h1f);
      wr(ADDR_FLAG, 8'hff);
      rd_check(ADDR_FLAG, 8'h40);
      wr(ADDR_ENABLE, 8'hff);
      rd_check(ADDR_ENABLE, 8'h40);
      wr(ADDR_INT_CTRL, 8'hff);
      rd_check(ADDR_INT_CTRL, 8'hff);
      check("irq_all_on", {7'h00, comparator_irq}, 8'h01);
      wr(ADDR_FLAG, 8'h00);
      check("irq_cleared", {7'h00, comparator_irq}, 8'h00);
      wr(ADDR_INT_CTRL, 8'h00);
      // Every mode with both switch settings
      for (int m = 0; m < 8; m++) begin
         for (int s = 0; s < 2; s++) begin
            wr(ADDR_CMP_CTRL, {4'h0, s[0], m[2:0]});
            tick(2);
            exp_route = '{comp_power: m != 7, vin_plus_ladder: m == 2,
               c1_inv_a3: s == 1 && (m == 1 || m == 2),
               c2_inv_a2: s == 1 && m == 2, pins_out_cmp: m == 6};
            check("route", {3'h0, route}, {3'h0, exp_route});
         end
      end
      // Ladder taps in both ranges, comparators off meanwhile
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 3; k++) begin
            lv = (k == 0) ? 7'h00 : (k == 1) ? 7'h06 : 7'h0f;
            wr(ADDR_REF_CTRL, {1'b1, 1'b0, r[0], 1'b0, lv[3:0]});
            tick(2);
            check("tap", {1'b0, ladder.num},
                  {1'b0, r == 1 ? 7'(4 * lv) : 7'(24 + 3 * lv)});
            check("ladder_on", {7'h00, ladder.power}, 8'h01);
         end
      end
      wr(ADDR_REF_CTRL, 8'h2f);
      tick(2);
      check("ladder_off", {7'h00, ladder.power}, 8'h00);
      // Reference pin needs direction bit and pin enable together
      for (int d = 0; d < 2; d++) begin
         for (int o = 0; o < 2; o++) begin
            wr(ADDR_DIR_A, {3'h0, 2'h3, d[0], 2'h3});
            wr(ADDR_REF_CTRL, {1'b0, o[0], 6'h00});
            tick(1);
            check("a2_ref", {7'h00, pin_a2_ref_en}, 8'(d & o));
            check("dir_out", {3'h0, port_a_dir},
                  {3'h0, 2'h3, d[0], 2'h3});
         end
      end
      // Change flag, enables, mismatch and sleep
      wr(ADDR_REF_CTRL, 8'ha6);
      wr(ADDR_CMP_CTRL, 8'h02);
      tick(4);
      wr(ADDR_FLAG, 8'h00);
      wr(ADDR_ENABLE, 8'h40);
      wr(ADDR_INT_CTRL, 8'hc0);
      @(posedge clk);
      ext_minus1 <= 7'h0a;
      tick(4);
      check("irq_on", {7'h00, comparator_irq}, 8'h01);
      wr(ADDR_INT_CTRL, 8'h40);
      check("irq_masked", {7'h00, comparator_irq}, 8'h00);
      rd_check(ADDR_FLAG, 8'h40);
      wr(ADDR_FLAG, 8'h00);
      rd_check(ADDR_FLAG, 8'h40);
      rd_check(ADDR_CMP_CTRL, 8'h42);
      wr(ADDR_FLAG, 8'h00);
      rd_check(ADDR_FLAG, 8'h00);
      @(posedge clk);
      ext_minus2 <= 7'h0a;
      tick(4);
      rd_check(ADDR_FLAG, 8'h40);
      rd_check(ADDR_CMP_CTRL, 8'hc2);
      wr(ADDR_FLAG, 8'h00);
      rd_check(ADDR_FLAG, 8'h00);
      wr(ADDR_FLAG, 8'h40);
      rd_check(ADDR_FLAG, 8'h40);
      @(posedge clk);
      sleep <= 1'b1;
      tick(1);
      check("wake", {7'h00, wake_req}, 8'h01);
      wr(ADDR_FLAG, 8'h00);
      check("no_wake", {7'h00, wake_req}, 8'h00);
      @(posedge clk);
      sleep <= 1'b0;
      rd_check(ADDR_CMP_CTRL, 8'hc2);
      rd_check(ADDR_REF_CTRL, 8'ha6);
      // Pin-out mode passes raw results in the same cycle
      wr(ADDR_CMP_CTRL, 8'h06);
      tick(1);
      @(posedge clk);
      ext_plus <= 7'h7f;
      #1;
      check("a3_raw", {6'h00, pin_a4_out, pin_a3_out}, 8'h03);
      @(posedge clk);
      ext_plus <= 7'h00;
      #1;
      check("a3_raw_low", {6'h00, pin_a4_out, pin_a3_out}, 8'h00);
      tick(4);
      rd_check(ADDR_CMP_CTRL, 8'h06);
      // Mid-run reset must clear both control registers again
      @(posedge clk);
      rst <= 1'b1;
      tick(2);
      check("power_in_reset2", {7'h00, route.comp_power}, 8'h00);
      @(posedge clk);
      rst <= 1'b0;
      rd_check(ADDR_CMP_CTRL, 8'h00);
      rd_check(ADDR_REF_CTRL, 8'h00);
      summarize();
   end
endmodule
